// ==== pkg/iag_pkg.sv ====
// constants for the audio dsp interrupt aggregator
package iag_pkg;
	localparam int unsigned NUM_POS = 16;
	localparam int unsigned POS_SW1 = 15;
	localparam int unsigned POS_SW0 = 14;
	localparam int unsigned POS_RSV1 = 13;
	localparam int unsigned POS_RSV0 = 12;
	localparam int unsigned POS_TMR2 = 11;
	localparam int unsigned POS_TMR1 = 10;
	localparam int unsigned POS_DMA = 9;
	localparam int unsigned POS_WDOG = 8;
	localparam int unsigned POS_STBY = 7;
	localparam int unsigned POS_TWI = 6;
	localparam int unsigned POS_ASP2 = 5;
	localparam int unsigned POS_ASP1 = 4;
	localparam int unsigned POS_UART = 3;
	localparam int unsigned POS_SPP = 2;
	localparam int unsigned POS_GPIO = 1;
	localparam int unsigned POS_HOST = 0;
	localparam int unsigned GPIO_LINES = 17;
	localparam int unsigned GPIO_SEL_W = 5;
	// positions that carry an input request
	localparam logic [15:0] INPUT_MASK = 16'h0ffe;
	// edge select encodings per input position
	typedef enum logic [1:0] {
		IAG_LEVEL = 2'b00,
		IAG_RISE = 2'b01,
		IAG_FALL = 2'b10,
		IAG_BOTH = 2'b11
	} iag_edge_t;
	// gpio routing modes
	typedef enum logic [1:0] {
		IAG_GPIO_OFF = 2'b00,
		IAG_GPIO_DIRECT = 2'b01,
		IAG_GPIO_CASCADE = 2'b10
	} iag_gmode_t;
	localparam logic [15:0] RST_PEND = 16'h0000;
endpackage : iag_pkg

// ==== hdl/iag_gpio_route.sv ====
// gpio interrupt routing: two direct core lines or one cascaded line
`timescale 1ns/10ps
module iag_gpio_route #(
	parameter int unsigned LINES = iag_pkg::GPIO_LINES,
	parameter int unsigned SEL_W = iag_pkg::GPIO_SEL_W
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [LINES-1:0] gpio_in,
	input wire iag_pkg::iag_gmode_t mode_in,
	input wire logic [SEL_W-1:0] sel_a_in,
	input wire logic [SEL_W-1:0] sel_b_in,
	output logic [1:0] core_irq_out,
	output logic cascade_n_out
);
	logic [1:0] core_d, core_q;
	logic casc_n_d, casc_n_q;
	logic bit_a, bit_b;

	always_comb begin
		bit_a = (32'(sel_a_in) < LINES) ? gpio_in[sel_a_in] : 1'b0;
		bit_b = (32'(sel_b_in) < LINES) ? gpio_in[sel_b_in] : 1'b0;
		core_d = 2'b00;
		casc_n_d = 1'b1;
		case (mode_in)
			iag_pkg::IAG_GPIO_DIRECT: begin
				core_d = {bit_b, bit_a};
			end
			iag_pkg::IAG_GPIO_CASCADE: begin
				casc_n_d = ~bit_a; // only one line cascades
			end
			default: begin
				core_d = 2'b00;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			core_q <= 2'b00;
			casc_n_q <= 1'b1;
		end else begin
			core_q <= core_d;
			casc_n_q <= casc_n_d;
		end
	end

	assign core_irq_out = core_q;
	assign cascade_n_out = casc_n_q;
endmodule : iag_gpio_route

// ==== hdl/iag_irq_aggregator.sv ====
// interrupt aggregator: conditioning, wake, software irqs, host pin
`timescale 1ns/10ps
// Behaviour
// - per-input conditioning with selectable edge behaviour
// - drives wake request and external host pin
// - positions 15, 14 are software core interrupts
// - fixed positions for peripheral interrupt sources
// - standby pin inverted, seen active high
// - position 1 gpio cascade is active low
// - gpio: two direct lines or one cascaded
// - host pin active low, driven by any host-enabled pending bit
module iag_irq_aggregator (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic tmr2_irq_in,
	input wire logic tmr1_irq_in,
	input wire logic dma_irq_in,
	input wire logic wdog_irq_in,
	input wire logic standby_n_in,
	input wire logic twi_irq_in,
	input wire logic asp2_irq_in,
	input wire logic asp1_irq_in,
	input wire logic uart_irq_in,
	input wire logic spp_irq_in,
	input wire logic [1:0] rsv_irq_in,
	input wire logic [iag_pkg::GPIO_LINES-1:0] gpio_in,
	input wire iag_pkg::iag_gmode_t gpio_mode_in,
	input wire logic [iag_pkg::GPIO_SEL_W-1:0] gpio_sel_a_in,
	input wire logic [iag_pkg::GPIO_SEL_W-1:0] gpio_sel_b_in,
	input wire logic [31:0] edge_sel_in,
	input wire logic [15:0] enable_in,
	input wire logic [15:0] wake_en_in,
	input wire logic [15:0] host_en_in,
	input wire logic [15:0] clear_in,
	input wire logic [1:0] sw_set_in,
	input wire logic [1:0] sw_clr_in,
	output logic [15:0] pending_out,
	output logic [1:0] sw_irq_out,
	output logic [1:0] gpio_core_irq_out,
	output logic wake_out,
	output logic host_irq_n_out
);
	// reset images of the registered groups; the host pin idles released
	localparam logic [15:0] PREV_RST = 16'h0000;
	localparam logic [1:0] SW_RST = 2'b00;
	localparam logic WAKE_RST = 1'b0;
	localparam logic HOST_N_RST = 1'b1;
	// each position takes two bits of the edge select word
	localparam int unsigned EDGE_W = 2;

	// raw requests, all active high, one bit per aggregator position
	logic [15:0] raw;
	// per-position event after edge selection
	logic [15:0] hit;
	logic [15:0] prev_d;
	logic [15:0] prev_q;
	logic [15:0] pend_d;
	logic [15:0] pend_q;
	logic [1:0] sw_d;
	logic [1:0] sw_q;
	logic [15:0] wake_src;
	logic wake_d;
	logic wake_q;
	logic [15:0] host_src;
	logic host_n_d;
	logic host_n_q;
	// cascaded gpio request, still active low as the route delivers it
	logic casc_n;

	iag_gpio_route #(
		.LINES(iag_pkg::GPIO_LINES),
		.SEL_W(iag_pkg::GPIO_SEL_W)
	) u_route (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.gpio_in(gpio_in),
		.mode_in(gpio_mode_in),
		.sel_a_in(gpio_sel_a_in),
		.sel_b_in(gpio_sel_b_in),
		.core_irq_out(gpio_core_irq_out),
		.cascade_n_out(casc_n)
	);

	always_comb begin
		raw = 16'h0000;
		raw[iag_pkg::POS_TMR2] = tmr2_irq_in;
		raw[iag_pkg::POS_TMR1] = tmr1_irq_in;
		raw[iag_pkg::POS_DMA] = dma_irq_in;
		raw[iag_pkg::POS_WDOG] = wdog_irq_in;
		raw[iag_pkg::POS_STBY] = ~standby_n_in;
		raw[iag_pkg::POS_TWI] = twi_irq_in;
		raw[iag_pkg::POS_ASP2] = asp2_irq_in;
		raw[iag_pkg::POS_ASP1] = asp1_irq_in;
		raw[iag_pkg::POS_UART] = uart_irq_in;
		raw[iag_pkg::POS_SPP] = spp_irq_in;
		raw[iag_pkg::POS_GPIO] = ~casc_n;
		// rsv_irq_in deliberately never reaches raw
		raw = raw & iag_pkg::INPUT_MASK;
	end

	// per-position edge selection on the conditioned, active-high level
	genvar g;
	generate
		for (g = 0; g < iag_pkg::NUM_POS; g++) begin : g_cond
			logic [EDGE_W-1:0] sel_code;
			logic now_lvl;
			logic was_lvl;
			logic sel_hit;
			assign sel_code = edge_sel_in[EDGE_W*g +: EDGE_W];
			assign now_lvl = raw[g];
			assign was_lvl = prev_q[g];
			// rise and fall compare against the level kept at the last edge
			always_comb begin
				case (iag_pkg::iag_edge_t'(sel_code))
					iag_pkg::IAG_LEVEL: begin
						sel_hit = now_lvl;
					end
					iag_pkg::IAG_RISE: begin
						sel_hit = now_lvl & ~was_lvl;
					end
					iag_pkg::IAG_FALL: begin
						sel_hit = ~now_lvl & was_lvl;
					end
					iag_pkg::IAG_BOTH: begin
						sel_hit = now_lvl ^ was_lvl;
					end
					default: begin
						sel_hit = 1'b0;
					end
				endcase
			end
			// level mode re-arms every cycle while the source stays high
			assign hit[g] = sel_hit;
		end
	endgenerate

	// edge history: the conditioned level sampled at the previous edge
	always_comb begin
		prev_d = raw;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// every conditioned input idles low, so no false edge follows
			prev_q <= PREV_RST;
		end else begin
			prev_q <= prev_d;
		end
	end

	// pending: sticky until cleared; set wins over clear so an event
	// arriving in the clearing cycle is never lost
	always_comb begin
		pend_d = pend_q & ~clear_in;
		pend_d = pend_d | (hit & enable_in);
		// reserved and output positions can never latch
		pend_d = pend_d & iag_pkg::INPUT_MASK;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend_q <= iag_pkg::RST_PEND;
		end else begin
			pend_q <= pend_d;
		end
	end

	// software lines: set beats clear, as for the pending bits; the core
	// drops its own line by pulsing the matching clear input
	always_comb begin
		sw_d = sw_q & ~sw_clr_in;
		sw_d = sw_d | sw_set_in;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sw_q <= SW_RST;
		end else begin
			sw_q <= sw_d;
		end
	end

	// wake request: taken from the next pending value so it rises on the
	// same edge as the bit that causes it
	always_comb begin
		wake_src = pend_d & wake_en_in;
		wake_d = |wake_src;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wake_q <= WAKE_RST;
		end else begin
			wake_q <= wake_d;
		end
	end

	// host pin: active low and level driven; it stays asserted until
	// every host-enabled pending bit is cleared, so a host that acks
	// only the source and not the pending bit sees it stuck low
	always_comb begin
		host_src = pend_d & host_en_in;
		host_n_d = ~(|host_src);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			host_n_q <= HOST_N_RST;
		end else begin
			host_n_q <= host_n_d;
		end
	end

	// every output is the flop itself, no logic after the registers
	// software lines land on core external inputs
	assign sw_irq_out = sw_q;
	assign pending_out = pend_q;
	assign wake_out = wake_q;
	assign host_irq_n_out = host_n_q;
endmodule : iag_irq_aggregator

// ==== tb/iag_irq_checker.sv ====
// port assertions for the interrupt aggregator
`timescale 1ns/10ps
module iag_irq_checker (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic tmr1_irq_in,
	input wire logic standby_n_in,
	input wire logic [31:0] edge_sel_in,
	input wire logic [15:0] enable_in,
	input wire logic [15:0] wake_en_in,
	input wire logic [15:0] host_en_in,
	input wire logic [1:0] sw_set_in,
	input wire logic [1:0] sw_clr_in,
	input wire logic [15:0] pending_out,
	input wire logic [1:0] sw_irq_out,
	input wire logic wake_out,
	input wire logic host_irq_n_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_rsv_quiet: assert property (pending_out[13:12] == 2'h0)
		else $error("rsv pending");
	a_tmr1_level: assert property (~|edge_sel_in[21:20] && enable_in[10]
		&& tmr1_irq_in |=> pending_out[10]) else $error("tmr1");
	a_stby_inv: assert property (~|edge_sel_in[15:14] && enable_in[7]
		&& !standby_n_in |=> pending_out[7]) else $error("standby");
	a_off_idle: assert property (!enable_in[10] && !pending_out[10]
		|=> !pending_out[10]) else $error("disabled");
	a_wake_follow: assert property ($stable(wake_en_in)
		|-> wake_out == |(pending_out & wake_en_in)) else $error("wake");
	a_host_pin: assert property ($stable(host_en_in)
		|-> host_irq_n_out == !(|(pending_out & host_en_in))) else $error("host");
	a_sw_set: assert property (sw_set_in[0] |=> sw_irq_out[0])
		else $error("sw set");
	a_sw_clear: assert property (sw_clr_in[1] && !sw_set_in[1]
		|=> !sw_irq_out[1]) else $error("sw clr");
	c_host: cover property (!host_irq_n_out);
	c_wake: cover property (wake_out);
	c_sw: cover property (sw_irq_out == 2'h3);
	c_casc: cover property (pending_out[1]);
endmodule : iag_irq_checker
bind iag_irq_aggregator iag_irq_checker chk_i (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.tmr1_irq_in(tmr1_irq_in),
	.standby_n_in(standby_n_in),
	.edge_sel_in(edge_sel_in),
	.enable_in(enable_in),
	.wake_en_in(wake_en_in),
	.host_en_in(host_en_in),
	.sw_set_in(sw_set_in),
	.sw_clr_in(sw_clr_in),
	.pending_out(pending_out),
	.sw_irq_out(sw_irq_out),
	.wake_out(wake_out),
	.host_irq_n_out(host_irq_n_out)
);

// ==== tb/iag_core_model.sv ====
// far side: core external interrupt inputs fed by the software lines
`timescale 1ns/10ps
module iag_core_model (
	input wire logic [1:0] sw_irq_in,
	output logic [15:0] core_ext_out
);
	// sixteen external inputs, software lines on the top two
	assign core_ext_out = {sw_irq_in, 14'h0};
endmodule : iag_core_model

// ==== tb/iag_irq_aggregator_test.sv ====
// self-checking bench for the interrupt aggregator
`timescale 1ns/10ps
module iag_irq_aggregator_test;
	logic clk_in = 1'b0, rst_n_in = 1'b0, wake_out, host_irq_n_out;
	logic [9:0] src = 10'h0;
	logic [1:0] rsv_irq_in = 2'h0, sw_set_in = 2'h0, sw_clr_in = 2'h0;
	logic [1:0] sw_irq_out, gpio_core_irq_out;
	wire tmr2_irq_in, tmr1_irq_in, dma_irq_in, wdog_irq_in, twi_irq_in;
	wire asp2_irq_in, asp1_irq_in, uart_irq_in, spp_irq_in, standby_n_in;
	logic [16:0] gpio_in = 17'h00000;
	iag_pkg::iag_gmode_t gpio_mode_in = iag_pkg::IAG_GPIO_CASCADE;
	logic [4:0] gpio_sel_a_in = 5'h10, gpio_sel_b_in = 5'h04;
	logic [31:0] edge_sel_in = 32'h0;
	logic [15:0] enable_in = 16'h0ffe, wake_en_in = 16'hffff;
	logic [15:0] host_en_in = 16'hffff, clear_in = 16'h0, pending_out, core;
	int err_total = 0, n_compared = 0;
	int pos[10] = '{2, 3, 4, 5, 6, 8, 9, 10, 11, 7};
	assign {standby_n_in, tmr2_irq_in, tmr1_irq_in, dma_irq_in, wdog_irq_in,
		twi_irq_in, asp2_irq_in, asp1_irq_in, uart_irq_in, spp_irq_in} =
		src ^ 10'h200;
	iag_irq_aggregator dut (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.tmr2_irq_in(tmr2_irq_in),
		.tmr1_irq_in(tmr1_irq_in),
		.dma_irq_in(dma_irq_in),
		.wdog_irq_in(wdog_irq_in),
		.standby_n_in(standby_n_in),
		.twi_irq_in(twi_irq_in),
		.asp2_irq_in(asp2_irq_in),
		.asp1_irq_in(asp1_irq_in),
		.uart_irq_in(uart_irq_in),
		.spp_irq_in(spp_irq_in),
		.rsv_irq_in(rsv_irq_in),
		.gpio_in(gpio_in),
		.gpio_mode_in(gpio_mode_in),
		.gpio_sel_a_in(gpio_sel_a_in),
		.gpio_sel_b_in(gpio_sel_b_in),
		.edge_sel_in(edge_sel_in),
		.enable_in(enable_in),
		.wake_en_in(wake_en_in),
		.host_en_in(host_en_in),
		.clear_in(clear_in),
		.sw_set_in(sw_set_in),
		.sw_clr_in(sw_clr_in),
		.pending_out(pending_out),
		.sw_irq_out(sw_irq_out),
		.gpio_core_irq_out(gpio_core_irq_out),
		.wake_out(wake_out),
		.host_irq_n_out(host_irq_n_out)
	);
	iag_core_model far (.sw_irq_in(sw_irq_out), .core_ext_out(core));
	always #50 clk_in = ~clk_in;
	task step(int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : step
	task chk(string what, logic [15:0] exp, logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task clr;
		clear_in <= 16'hffff;
		step(1);
		clear_in <= 16'h0;
		step(1);
	endtask : clr
	task t_sources;
		for (int i = 0; i < 10; i++) begin
			src <= 10'h1 << i;
			step(1);
			chk("pending", 16'h1 << pos[i], pending_out);
			chk("wake", 16'h1, wake_out);
			chk("host", 16'h0, host_irq_n_out);
			src <= 10'h0;
			clr();
		end
		$display("sources done");
	endtask : t_sources
	task t_gate;
		wake_en_in <= 16'h0400;
		host_en_in <= 16'h0008;
		src <= 10'h080;
		step(1);
		chk("pending", 16'h0400, pending_out);
		chk("wake", 16'h1, wake_out);
		chk("host", 16'h1, host_irq_n_out);
		src <= 10'h0;
		clr();
		wake_en_in <= 16'h0008;
		host_en_in <= 16'h0400;
		src <= 10'h080;
		step(1);
		chk("wake", 16'h0, wake_out);
		chk("host", 16'h0, host_irq_n_out);
		src <= 10'h0;
		wake_en_in <= 16'hffff;
		host_en_in <= 16'hffff;
		clr();
		$display("gate done");
	endtask : t_gate
	task t_edge;
		edge_sel_in <= 32'h0010_0000;
		src <= 10'h080;
		step(1);
		chk("rise", 16'h0400, pending_out);
		step(2);
		clr();
		step(2);
		chk("held level", 16'h0, pending_out);
		edge_sel_in <= 32'h0020_0000;
		src <= 10'h0;
		step(1);
		chk("fall", 16'h0400, pending_out);
		clr();
		src <= 10'h080;
		step(2);
		chk("fall on rise", 16'h0, pending_out);
		edge_sel_in <= 32'h0030_0000;
		src <= 10'h0;
		step(1);
		chk("both", 16'h0400, pending_out);
		edge_sel_in <= 32'h0;
		clr();
		$display("edge done");
	endtask : t_edge
	task t_reserved;
		enable_in <= 16'h3000;
		rsv_irq_in <= 2'h3;
		src <= 10'h3ff;
		step(2);
		chk("pending", 16'h0, pending_out);
		src <= 10'h0;
		rsv_irq_in <= 2'h0;
		enable_in <= 16'h0ffe;
		clr();
		$display("reserved done");
	endtask : t_reserved
	task t_soft;
		sw_set_in <= 2'h3;
		step(1);
		sw_set_in <= 2'h1;
		sw_clr_in <= 2'h3;
		chk("core", 16'hc000, core);
		step(1);
		chk("sw", 16'h1, sw_irq_out);
		sw_set_in <= 2'h0;
		step(1);
		sw_clr_in <= 2'h0;
		chk("sw", 16'h0, sw_irq_out);
		$display("soft done");
	endtask : t_soft
	task t_gpio;
		gpio_in <= 17'h10000;
		step(2);
		chk("pending", 16'h0002, pending_out);
		chk("direct", 16'h0, gpio_core_irq_out);
		gpio_mode_in <= iag_pkg::IAG_GPIO_DIRECT;
		gpio_sel_a_in <= 5'h03;
		gpio_in <= 17'h00018;
		step(2);
		clr();
		chk("pending", 16'h0, pending_out);
		chk("direct", 16'h3, gpio_core_irq_out);
		$display("gpio done");
	endtask : t_gpio
	task give_verdict;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		step(1);
		chk("reset", iag_pkg::RST_PEND, pending_out);
		chk("host", 16'h1, host_irq_n_out);
		chk("wake", 16'h0, wake_out);
		t_sources();
		t_gate();
		t_edge();
		t_reserved();
		t_soft();
		t_gpio();
		give_verdict();
	end
endmodule : iag_irq_aggregator_test
